//--- src/dbgs_map.svh
// constants of the dual buck gate sequencer: clock, switching and timing figures
`ifndef DBGS_MAP_SVH
`define DBGS_MAP_SVH

// ----------------------------------------------------------------
// clocking
// ----------------------------------------------------------------
`define DBGS_CLK_HZ 100000000
`define DBGS_CLK_NS 10

// ----------------------------------------------------------------
// switching timing
// ----------------------------------------------------------------
`define DBGS_SW_HZ 550000
`define DBGS_NOV_NS 20
`define DBGS_PG_DELAY_NS 100000

// ----------------------------------------------------------------
// reset values
// ----------------------------------------------------------------
`define DBGS_RST_PHASE 8'h00
`define DBGS_RST_NOV 4'h0
`define DBGS_RST_PG_CNT 14'h0000

`endif

//--- src/dbgs_pkg.sv
// types shared by the dual buck gate sequencer
package dbgs_pkg;

    // ----------------------------------------------------------------
    // per-channel gate sequencing states, one-hot
    // ----------------------------------------------------------------
    typedef enum logic [5:0] {
        ST_OFF     = 6'h01,
        ST_WAIT_HS = 6'h02,
        ST_HS      = 6'h04,
        ST_WAIT_LS = 6'h08,
        ST_LS      = 6'h10,
        ST_IDLE    = 6'h20
    } dbgs_gate_st_t;

    // ----------------------------------------------------------------
    // state of the top-level sequencer
    // ----------------------------------------------------------------
    typedef struct packed {
        logic [7:0] phase;
        logic [1:0][5:0] st;
        logic [1:0][3:0] nov;
        logic [1:0] hs;
        logic [1:0] ls;
        logic [1:0] ramp;
    } dbgs_seq_t;

    // ----------------------------------------------------------------
    // state of one power-good filter
    // ----------------------------------------------------------------
    typedef struct packed {
        logic [13:0] cnt;
        logic run;
        logic pull;
    } dbgs_pg_t;

endpackage : dbgs_pkg

//--- src/dbgs_power_good_output.sv
// power-good glitch filter and open-drain control for one channel
`timescale 1ns/1ps
`include "dbgs_map.svh"

module dbgs_power_good_output #(
    parameter int PG_CYC = 10000
) (
    input wire logic i_clk_sys,
    input wire logic i_rstn,
    input wire logic i_run,
    input wire logic i_uv,
    output logic o_pg_out,
    output logic o_pg_oe_n
);

    dbgs_pkg::dbgs_pg_t s_q;
    dbgs_pkg::dbgs_pg_t s_d;

    // ----------------------------------------------------------------
    // next state
    // ----------------------------------------------------------------
    always_comb begin
        s_d = s_q;
        s_d.run = i_run;
        if (!i_run) begin
            // shutdown: release the pin
            s_d.pull = 1'b0;
            s_d.cnt = `DBGS_RST_PG_CNT;
        end else if (!s_q.run) begin
            // leaving shutdown: hold low until output valid
            s_d.pull = 1'b1;
            s_d.cnt = `DBGS_RST_PG_CNT;
        end else if (!i_uv) begin
            s_d.pull = 1'b0;
            s_d.cnt = `DBGS_RST_PG_CNT;
        end else if (s_q.cnt == 14'(PG_CYC)) begin
            // undervoltage held past the delay: pull the pin low
            s_d.pull = 1'b1;
        end else begin
            s_d.cnt = s_q.cnt + 14'h0001;
        end
    end

    // ----------------------------------------------------------------
    // state register
    // ----------------------------------------------------------------
    always_ff @(posedge i_clk_sys or negedge i_rstn) begin
        if (!i_rstn) begin
            s_q <= '0;
        end else begin
            s_q <= s_d;
        end
    end

    // open drain: never drives high
    assign o_pg_out = 1'b0;
    assign o_pg_oe_n = ~s_q.pull;

    // ----------------------------------------------------------------
    // checks
    // ----------------------------------------------------------------
    a_pg_shutdown_release: assert property (
        @(posedge i_clk_sys) disable iff (!i_rstn)
        !i_run |=> o_pg_oe_n
    ) else $error("power good not released in shutdown");

    a_pg_startup_low: assert property (
        @(posedge i_clk_sys) disable iff (!i_rstn)
        i_run && !$past(i_run) |=> !o_pg_oe_n
    ) else $error("power good not low on leaving shutdown");

    a_pg_short_glitch: assert property (
        @(posedge i_clk_sys) disable iff (!i_rstn)
        $fell(o_pg_oe_n) |-> !$past(s_q.run) || $past(s_q.cnt) == 14'(PG_CYC)
    ) else $error("power good pulled low before the delay");

endmodule : dbgs_power_good_output

//--- src/dbgs_top.sv
// dual buck gate sequencer with power-good outputs
`timescale 1ns/1ps
`include "dbgs_map.svh"

module dbgs_top #(
    parameter int PG_CYC = (`DBGS_PG_DELAY_NS + `DBGS_CLK_NS - 1) / `DBGS_CLK_NS
) (
    input wire logic i_clk_sys,
    input wire logic i_rstn,
    input wire logic [1:0] i_run,
    input wire logic [1:0] i_pwm_end,
    input wire logic [1:0] i_feedback_sense_uv,
    input wire logic [1:0] i_zero_cross,
    input wire logic i_force_continuous_input_n,
    input wire logic i_fault,
    output logic [1:0] o_high_side_gate_drive,
    output logic [1:0] o_low_side_gate_drive,
    output logic [1:0] o_ramp_reset,
    output logic [1:0] o_power_good_output,
    output logic [1:0] o_power_good_output_oe_n
);

    // ----------------------------------------------------------------
    // derived cycle counts
    // ----------------------------------------------------------------
    localparam int PER_CYC = `DBGS_CLK_HZ / `DBGS_SW_HZ;
    localparam int HALF_CYC = PER_CYC / 2;
    localparam int NOV_CYC = (`DBGS_NOV_NS + `DBGS_CLK_NS - 1) / `DBGS_CLK_NS;
    localparam logic [7:0] PER_LAST = 8'(PER_CYC - 1);
    localparam logic [7:0] HALF_PH = 8'(HALF_CYC);
    localparam logic [3:0] NOV_LAST = 4'(NOV_CYC - 1);

    dbgs_pkg::dbgs_seq_t s_q;
    dbgs_pkg::dbgs_seq_t s_d;
    logic [1:0] tick;

    // ----------------------------------------------------------------
    // master clock ticks, channel 2 half a period behind
    // ----------------------------------------------------------------
    assign tick[0] = (s_q.phase == 8'h00);
    assign tick[1] = (s_q.phase == HALF_PH);

    // ----------------------------------------------------------------
    // next state
    // ----------------------------------------------------------------
    always_comb begin
        s_d = s_q;
        // one shared phase counter for both channels
        if (s_q.phase == PER_LAST) begin
            s_d.phase = `DBGS_RST_PHASE;
        end else begin
            s_d.phase = s_q.phase + 8'h01;
        end
        s_d.ramp = tick;
        for (int c = 0; c < 2; c++) begin
            if (i_fault || !i_run[c]) begin
                // shared fault or own shutdown: both switches off
                s_d.st[c] = dbgs_pkg::ST_OFF;
                s_d.hs[c] = 1'b0;
                s_d.ls[c] = 1'b0;
                s_d.nov[c] = `DBGS_RST_NOV;
            end else if (tick[c] && s_q.st[c] != dbgs_pkg::ST_HS) begin
                // new cycle: low side off first
                s_d.st[c] = dbgs_pkg::ST_WAIT_HS;
                s_d.ls[c] = 1'b0;
                s_d.hs[c] = 1'b0;
                s_d.nov[c] = `DBGS_RST_NOV;
            end else begin
                case (s_q.st[c])
                    dbgs_pkg::ST_WAIT_HS: begin
                        // nonoverlap before high side
                        if (s_q.nov[c] == NOV_LAST) begin
                            s_d.hs[c] = 1'b1;
                            s_d.st[c] = dbgs_pkg::ST_HS;
                        end else begin
                            s_d.nov[c] = s_q.nov[c] + 4'h1;
                        end
                    end
                    dbgs_pkg::ST_HS: begin
                        // pulse ends when the comparator trips
                        if (i_pwm_end[c]) begin
                            s_d.hs[c] = 1'b0;
                            s_d.st[c] = dbgs_pkg::ST_WAIT_LS;
                            s_d.nov[c] = `DBGS_RST_NOV;
                        end
                    end
                    dbgs_pkg::ST_WAIT_LS: begin
                        // nonoverlap before low side
                        if (s_q.nov[c] == NOV_LAST) begin
                            s_d.ls[c] = 1'b1;
                            s_d.st[c] = dbgs_pkg::ST_LS;
                        end else begin
                            s_d.nov[c] = s_q.nov[c] + 4'h1;
                        end
                    end
                    dbgs_pkg::ST_LS: begin
                        // without forced continuous, stop at current reversal
                        if (i_force_continuous_input_n && i_zero_cross[c]) begin
                            s_d.ls[c] = 1'b0;
                            s_d.st[c] = dbgs_pkg::ST_IDLE;
                        end
                    end
                    dbgs_pkg::ST_IDLE: begin
                        s_d.st[c] = dbgs_pkg::ST_IDLE;
                    end
                    default: begin
                        // off: wait for the channel's tick
                        s_d.st[c] = dbgs_pkg::ST_OFF;
                        s_d.hs[c] = 1'b0;
                        s_d.ls[c] = 1'b0;
                    end
                endcase
            end
        end
    end

    // ----------------------------------------------------------------
    // state register
    // ----------------------------------------------------------------
    always_ff @(posedge i_clk_sys or negedge i_rstn) begin
        if (!i_rstn) begin
            s_q.phase <= `DBGS_RST_PHASE;
            s_q.st <= {dbgs_pkg::ST_OFF, dbgs_pkg::ST_OFF};
            s_q.nov <= {`DBGS_RST_NOV, `DBGS_RST_NOV};
            s_q.hs <= 2'h0;
            s_q.ls <= 2'h0;
            s_q.ramp <= 2'h0;
        end else begin
            s_q <= s_d;
        end
    end

    // gate drives from flip-flops
    assign o_high_side_gate_drive = s_q.hs;
    assign o_low_side_gate_drive = s_q.ls;
    assign o_ramp_reset = s_q.ramp;

    // ----------------------------------------------------------------
    // power-good per channel, independent filters
    // ----------------------------------------------------------------
    for (genvar g = 0; g < 2; g++) begin : g_pg
        dbgs_power_good_output #(
            .PG_CYC(PG_CYC)
        ) u_pg (
            .i_clk_sys(i_clk_sys),
            .i_rstn(i_rstn),
            .i_run(i_run[g]),
            .i_uv(i_feedback_sense_uv[g]),
            .o_pg_out(o_power_good_output[g]),
            .o_pg_oe_n(o_power_good_output_oe_n[g])
        );
    end

    // ----------------------------------------------------------------
    // checks
    // ----------------------------------------------------------------
    a_no_shoot_through: assert property (
        @(posedge i_clk_sys) disable iff (!i_rstn)
        !(s_q.hs[0] && s_q.ls[0]) && !(s_q.hs[1] && s_q.ls[1])
    ) else $error("high and low side on together");

    a_hs_after_gap: assert property (
        @(posedge i_clk_sys) disable iff (!i_rstn)
        $rose(o_high_side_gate_drive[0]) |-> $past(!o_low_side_gate_drive[0], 1)
            && $past(!o_low_side_gate_drive[0], 2)
    ) else $error("high side on without nonoverlap gap");

    a_ls_after_gap: assert property (
        @(posedge i_clk_sys) disable iff (!i_rstn)
        $rose(o_low_side_gate_drive[1]) |-> $past(!o_high_side_gate_drive[1], 1)
            && $past(!o_high_side_gate_drive[1], 2)
    ) else $error("low side on without nonoverlap gap");

    a_cycle_period: assert property (
        @(posedge i_clk_sys) disable iff (!i_rstn)
        o_ramp_reset[0] |-> ##181 o_ramp_reset[0]
    ) else $error("master clock period wrong");

    a_half_phase: assert property (
        @(posedge i_clk_sys) disable iff (!i_rstn)
        o_ramp_reset[0] |-> ##1 !o_ramp_reset[1] ##89 o_ramp_reset[1]
    ) else $error("channel 2 not half a period behind");

    a_hs_on_tick: assert property (
        @(posedge i_clk_sys) disable iff (!i_rstn)
        o_ramp_reset[0] && $past(i_run[0] && !i_fault) && i_run[0] && !i_fault
            ##1 i_run[0] && !i_fault |=> o_high_side_gate_drive[0]
    ) else $error("high side not on two cycles after tick");

    a_hs_off_pulse: assert property (
        @(posedge i_clk_sys) disable iff (!i_rstn)
        o_high_side_gate_drive[0] && i_pwm_end[0] && !tick[0] |=> !o_high_side_gate_drive[0]
    ) else $error("high side stays on after pulse end");

    a_fault_both_off: assert property (
        @(posedge i_clk_sys) disable iff (!i_rstn)
        i_fault |=> o_high_side_gate_drive == 2'h0 && o_low_side_gate_drive == 2'h0
    ) else $error("fault did not stop both channels");

endmodule : dbgs_top

//--- tb/dbgs_fet_model.sv
// power stage model: two switch pairs and the pulled-up power-good lines
`timescale 1ns/1ps

module dbgs_fet_model (
    input wire logic i_clk_sys,
    input wire logic [1:0] i_hs,
    input wire logic [1:0] i_ls,
    input wire logic [1:0] i_pg_out,
    input wire logic [1:0] i_pg_oe_n,
    output logic [1:0] o_switch_node,
    output logic [1:0] o_pg_line,
    output logic o_shoot
);
    logic [1:0] sw_q = 2'h0;

    // ----------------------------------------------------------------
    // switch node follows whichever switch conducts
    // ----------------------------------------------------------------
    always_ff @(posedge i_clk_sys) begin
        for (int c = 0; c < 2; c++) begin
            if (i_hs[c]) begin
                sw_q[c] <= 1'b1;
            end else if (i_ls[c]) begin
                sw_q[c] <= 1'b0;
            end else begin
                sw_q[c] <= ~sw_q[c]; // floating node shows no stale level
            end
        end
    end
    assign o_switch_node = sw_q;

    // released pin reads high through the pull-up
    assign o_pg_line = i_pg_oe_n | i_pg_out;
    // both switches on would short the input rail
    assign o_shoot = |(i_hs & i_ls);
endmodule : dbgs_fet_model

//--- tb/dual_buck_gate_sequencer_power_good_output_tb.sv
// self-checking bench of the dual buck gate sequencer
`timescale 1ns/1ps
`define CHK(a, b) begin samples_checked++; if ((a) !== (b)) begin bad_count++; \
$display("Error t=%0t got %0h exp %0h", $time, (a), (b)); end end

module dual_buck_gate_sequencer_power_good_output_tb;
    localparam int PG = 20;
    localparam int LIMIT = 20000;
    logic i_clk_sys = 1'b0;
    logic i_rstn = 1'b0;
    logic [1:0] run = 2'h0, pwm_end = 2'h0, uv = 2'h0, zc = 2'h0;
    logic fcb_n = 1'b0, fault = 1'b0;
    logic [1:0] hs, ls, ramp, pg_out, pg_oe_n, sw, pg_line;
    logic shoot;
    logic [1:0] was_hs = 2'h0, killed = 2'h0, expd = 2'h0, prun = 2'h0;
    logic [1:0] hs_prev = 2'h0; // high side seen at the previous edge
    logic [2:0] okh [2] = '{3'h0, 3'h0};
    int bad_count = 0, samples_checked = 0, cyc = 0, last0 = 0;
    int hs_cnt[2] = '{0, 0}, gap[2] = '{0, 0}, duty[2] = '{1, 1};
    int age[2] = '{-1, -1}, uvk[2] = '{0, 0};

    dbgs_top #(.PG_CYC(PG)) dut (.i_clk_sys(i_clk_sys), .i_rstn(i_rstn), .i_run(run),
        .i_pwm_end(pwm_end), .i_feedback_sense_uv(uv), .i_zero_cross(zc),
        .i_force_continuous_input_n(fcb_n), .i_fault(fault), .o_high_side_gate_drive(hs),
        .o_low_side_gate_drive(ls), .o_ramp_reset(ramp), .o_power_good_output(pg_out),
        .o_power_good_output_oe_n(pg_oe_n));
    dbgs_fet_model stage (.i_clk_sys(i_clk_sys), .i_hs(hs), .i_ls(ls), .i_pg_out(pg_out),
        .i_pg_oe_n(pg_oe_n), .o_switch_node(sw), .o_pg_line(pg_line), .o_shoot(shoot));

    // ----------------------------------------------------------------
    // clock and closing report
    // ----------------------------------------------------------------
    initial begin
        forever #5 i_clk_sys = ~i_clk_sys;
    end

    task automatic print_verdict();
        $display("checks %0d mismatches %0d", samples_checked, bad_count);
        if (bad_count == 0 && samples_checked > 0) begin
            $display("Result: passed");
        end else begin
            $display("Result: failed");
        end
        $finish;
    endtask : print_verdict

    // ----------------------------------------------------------------
    // monitor: sees values from before this edge lands
    // ----------------------------------------------------------------
    always @(posedge i_clk_sys) begin
        cyc++;
        if (cyc == LIMIT) begin
            bad_count++;
            print_verdict();
        end
        if (i_rstn) begin
            `CHK(shoot, 1'b0)
            `CHK(pg_out, 2'h0)
            if (ramp[0]) begin
                if (last0 != 0) `CHK(cyc - last0, 181)
                last0 = cyc;
            end
            if (ramp[1] && last0 != 0) `CHK(cyc - last0, 90)
            if (fault || !run[0]) last0 = 0;
            for (int c = 0; c < 2; c++) begin
                if (!okh[c][0]) `CHK({hs[c], ls[c]}, 2'h0)
                if (ramp[c]) begin
                    `CHK({hs[c], ls[c]}, 2'h0)
                    age[c] = 0;
                end else if (age[c] >= 0) begin
                    age[c]++;
                end
                if (age[c] == 2) begin
                    if (&okh[c]) `CHK(hs[c], 1'b1)
                    age[c] = -1;
                end
                // pulse end fed back once the wanted on-time is reached
                if (hs[c]) hs_cnt[c]++;
                pwm_end[c] <= hs[c] && hs_cnt[c] >= duty[c];
                if (!(run[c] && !fault)) killed[c] = 1'b1;
                if (!hs[c] && hs_cnt[c] > 0) begin
                    if (!killed[c]) `CHK(hs_cnt[c], duty[c] + 1)
                    hs_cnt[c] = 0;
                    killed[c] = 1'b0;
                    duty[c] = 1 + $urandom % 150;
                end
                // dead time between the two gates
                if (!hs[c] && !ls[c]) begin
                    gap[c]++;
                end else begin
                    if (ls[c] && gap[c] > 0 && was_hs[c]) `CHK(gap[c], 2)
                    if (hs[c] && gap[c] > 0) `CHK(gap[c] >= 2, 1'b1)
                    gap[c] = 0;
                    was_hs[c] = hs[c];
                end
                // power-good reference filter
                if (uvk[c] != PG + 1) `CHK(pg_oe_n[c], ~expd[c])
                if (uvk[c] != PG + 1) `CHK(pg_line[c], ~expd[c])
                // host reads power good only while the channel runs
                if (prun[c]) `CHK(pg_line[c], pg_oe_n[c])
                // switch node pulled up while the high side conducted
                if (hs_prev[c]) `CHK(sw[c], 1'b1)
                hs_prev[c] = hs[c];
                if (!run[c]) expd[c] = 1'b0;
                else if (!prun[c]) expd[c] = 1'b1;
                else if (!uv[c]) expd[c] = 1'b0;
                uvk[c] = (run[c] && uv[c]) ? uvk[c] + 1 : 0;
                if (uvk[c] >= PG + 1) expd[c] = 1'b1;
                prun[c] = run[c];
                okh[c] = {okh[c][1:0], run[c] & ~fault};
            end
        end
    end

    // ----------------------------------------------------------------
    // stimulus: directed corners, then random traffic
    // ----------------------------------------------------------------
    initial begin
        void'($urandom(94));
        repeat (20) @(posedge i_clk_sys);
        i_rstn <= 1'b1;
        repeat (3) @(posedge i_clk_sys);
        run <= 2'h3;
        repeat (1100) @(posedge i_clk_sys);
        // short sag stays hidden, long sag shows on channel 1 only
        uv[0] <= 1'b1;
        repeat (PG) @(posedge i_clk_sys);
        uv[0] <= 1'b0;
        repeat (50) @(posedge i_clk_sys);
        uv[0] <= 1'b1;
        repeat (PG + 10) @(posedge i_clk_sys);
        uv[0] <= 1'b0;
        // channel 2 shut down with a sagging output, then restarted
        uv[1] <= 1'b1;
        run[1] <= 1'b0;
        repeat (400) @(posedge i_clk_sys);
        run[1] <= 1'b1;
        repeat (5) @(posedge i_clk_sys);
        uv[1] <= 1'b0;
        repeat (300) @(posedge i_clk_sys);
        fault <= 1'b1;
        repeat (50) @(posedge i_clk_sys);
        fault <= 1'b0;
        repeat (400) @(posedge i_clk_sys);
        repeat (6000) begin
            @(posedge i_clk_sys);
            zc <= 2'($urandom);
            if ($urandom % 40 == 0) uv <= uv ^ 2'($urandom);
            if ($urandom % 600 == 0) run <= run ^ 2'($urandom);
            if ($urandom % 1500 == 0) fault <= ~fault;
            if ($urandom % 300 == 0) fcb_n <= ~fcb_n;
        end
        print_verdict();
    end
endmodule : dual_buck_gate_sequencer_power_good_output_tb
